/* File: hw/cadence_regs.vh */
`ifndef CADENCE_REGS_VH
`define CADENCE_REGS_VH

// register byte addresses on the control port
`define ADDR_RING_CTRL 8'h22
`define ADDR_METER_CTRL 8'h23
`define ADDR_T1_ON_LO 8'h24
`define ADDR_T1_ON_HI 8'h25
`define ADDR_T1_OFF_LO 8'h26
`define ADDR_T1_OFF_HI 8'h27
`define ADDR_T2_ON_LO 8'h28
`define ADDR_T2_ON_HI 8'h29
`define ADDR_T2_OFF_LO 8'h2A
`define ADDR_T2_OFF_HI 8'h2B

// control register field positions
`define BIT_STATUS 7
`define BIT_RSVD6 6
`define BIT_ON_LINE 5
`define BIT_ON_TEN 4
`define BIT_OFF_TEN 3
`define BIT_GEN_ON 2
`define BIT_DC_OFS 1
`define BIT_SHAPE 0

// reset values
`define RST_BYTE 8'h00
`define RST_DUR 16'h0000
`define RST_BIT 1'b0

// cadence unit and clock period
`define CAD_UNIT_NS 125000
`define CLK_PERIOD_NS 8
`define DUR_W 16

// cadence channel indexes
`define CH_RING 0
`define CH_METER 1
`define CH_TONE1 2
`define CH_TONE2 3
`define NUM_CH 4

`endif

/* File: hw/cadence_timer.v */
`timescale 1ns/10ps
`include "cadence_regs.vh"

// one oscillator's on/off cadence sequencer, advanced by the unit tick
module cadence_timer (
  input wire ref_clk, // system clock
  input wire rst_n, // async reset, active low
  input wire unit_tick, // one pulse per cadence unit
  input wire gen_on, // oscillator enable
  input wire on_timer_en, // active-period timer enable
  input wire off_timer_en, // inactive-period timer enable
  input wire [15:0] on_duration, // active period in units
  input wire [15:0] off_duration, // inactive period in units
  output wire output_active // oscillator output on
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ON = 2'h1;
  localparam [1:0] ST_OFF = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;
  wire [15:0] cnt_inc;

  assign cnt_inc = cnt_q + 16'h0001;

  always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
      ST_IDLE: begin
        cnt_d = `RST_DUR;
        if (gen_on) begin
          state_d = ST_ON;
        end
      end
      ST_ON: begin
        if (on_timer_en && unit_tick) begin
          if (cnt_inc >= on_duration) begin
            cnt_d = `RST_DUR;
            state_d = off_timer_en ? ST_OFF : ST_DONE;
          end else begin
            cnt_d = cnt_inc;
          end
        end
      end
      ST_OFF: begin
        if (off_timer_en && unit_tick) begin
          if (cnt_inc >= off_duration) begin
            cnt_d = `RST_DUR;
            state_d = ST_ON;
          end else begin
            cnt_d = cnt_inc;
          end
        end
      end
      ST_DONE: begin
        cnt_d = `RST_DUR;
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d = `RST_DUR;
      end
    endcase
    if (!gen_on) begin
      state_d = ST_IDLE;
      cnt_d = `RST_DUR;
    end
  end

  // state and counter flops
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= `RST_DUR;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  assign output_active = (state_q == ST_ON);

endmodule // cadence_timer

/* File: hw/ring_tone_cadence_control.v */
`timescale 1ns/10ps
`include "cadence_regs.vh"

// Summary of operation
// - ringing control bit 7 reads one while ringing output is active
// - ringing reaches the line only at a dc-feed join point
// - bit 5 reads one only while ringing is applied to the line
// - ringing bit 4 enables the ringing active-period timer
// - ringing bit 3 enables the ringing inactive-period timer
// - ringing bit 2 reads one while the ringing oscillator is enabled
// - ringing bit 1 adds a dc offset to the ringing waveform
// - ringing bit 0 selects sinusoid (0) or trapezoid (1)
// - meter control bit 7 reads one while metering output is active
// - meter bit 4 enables the metering active-period timer
// - meter bit 3 enables the metering inactive-period timer
// - meter bit 2 enables metering; bits 6:5 and 1:0 read zero
// - tone 1 active duration, 16 bits in two bytes, 125 us units
// - tone 1 inactive duration, 16 bits in two bytes, 125 us units
// - tone 2 active duration, 16 bits in two bytes, 125 us units
// - tone 2 inactive duration, 16 bits in two bytes, 125 us units
// - each tone has separate active and inactive timer enables
// - ringing and metering durations are held outside, 125 us units
module ring_tone_cadence_control #(
  parameter UNIT_CYCLES = `CAD_UNIT_NS / `CLK_PERIOD_NS // cycles per unit
) (
  input wire ref_clk, // 125 MHz clock
  input wire rst_n, // async reset, active low
  input wire [7:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe, one cycle
  input wire reg_rd, // read strobe, one cycle
  output reg [7:0] reg_rdata, // read data, valid after reg_rd
  input wire ring_generator_on, // ringing oscillator enabled
  input wire ring_join_point, // ringing level meets dc feed
  input wire [15:0] ring_on_duration, // ringing active period
  input wire [15:0] ring_off_duration, // ringing inactive period
  input wire [15:0] meter_on_duration, // metering active period
  input wire [15:0] meter_off_duration, // metering inactive period
  input wire tone1_generator_on, // tone 1 enabled
  input wire tone1_on_timer_en, // tone 1 active timer enable
  input wire tone1_off_timer_en, // tone 1 inactive timer enable
  input wire tone2_generator_on, // tone 2 enabled
  input wire tone2_on_timer_en, // tone 2 active timer enable
  input wire tone2_off_timer_en, // tone 2 inactive timer enable
  output reg ring_output_active, // ringing oscillator output on
  output reg ring_on_line_flag, // ringing applied to the line pair
  output reg ring_dc_offset_en, // add dc offset to ringing
  output reg ring_shape_select, // 0 sinusoid, 1 trapezoid
  output reg meter_output_active, // metering output on
  output reg meter_generator_on, // metering oscillator enable
  output reg tone1_output_active, // tone 1 output on
  output reg tone2_output_active // tone 2 output on
);

  reg ring_on_timer_en_q;
  reg ring_off_timer_en_q;
  reg meter_on_timer_en_q;
  reg meter_off_timer_en_q;
  reg [15:0] tone1_on_duration_q;
  reg [15:0] tone1_off_duration_q;
  reg [15:0] tone2_on_duration_q;
  reg [15:0] tone2_off_duration_q;
  reg [15:0] unit_cnt_q;
  reg unit_tick_q;
  reg [7:0] rd_mux;
  // line drive states around the dc-feed join points
  localparam [1:0] LN_OFF = 2'h0; // waveform off the line
  localparam [1:0] LN_WAIT_ON = 2'h1; // start held for a join point
  localparam [1:0] LN_ON = 2'h2; // waveform on the line
  localparam [1:0] LN_WAIT_OFF = 2'h3; // stop held for a join point
  reg [1:0] line_state_q;
  reg [1:0] line_state_d;
  wire wr_ring_ctrl;
  wire wr_meter_ctrl;
  wire [31:0] unit_span;
  wire [`NUM_CH-1:0] ch_gen_on;
  wire [`NUM_CH-1:0] ch_on_en;
  wire [`NUM_CH-1:0] ch_off_en;
  wire [`NUM_CH*16-1:0] ch_on_dur;
  wire [`NUM_CH*16-1:0] ch_off_dur;
  wire [`NUM_CH-1:0] ch_active;
  wire [15:0] unit_last;

  assign unit_span = UNIT_CYCLES - 1;
  assign unit_last = unit_span[15:0];

  // write strobes of the two control registers
  assign wr_ring_ctrl = reg_wr && (reg_addr == `ADDR_RING_CTRL);
  assign wr_meter_ctrl = reg_wr && (reg_addr == `ADDR_METER_CTRL);

  // cadence unit tick, one pulse per 125 us
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      unit_cnt_q <= `RST_DUR;
      unit_tick_q <= `RST_BIT;
    end else if (unit_cnt_q == unit_last) begin
      unit_cnt_q <= `RST_DUR;
      unit_tick_q <= 1'b1;
    end else begin
      unit_cnt_q <= unit_cnt_q + 16'h0001;
      unit_tick_q <= 1'b0;
    end
  end

  // ringing control fields, read-only bits ignored
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_on_timer_en_q <= `RST_BIT;
      ring_off_timer_en_q <= `RST_BIT;
      ring_dc_offset_en <= `RST_BIT;
      ring_shape_select <= `RST_BIT;
    end else if (wr_ring_ctrl) begin
      ring_on_timer_en_q <= reg_wdata[`BIT_ON_TEN];
      ring_off_timer_en_q <= reg_wdata[`BIT_OFF_TEN];
      ring_dc_offset_en <= reg_wdata[`BIT_DC_OFS];
      ring_shape_select <= reg_wdata[`BIT_SHAPE];
    end
  end

  // metering control fields, status bit ignored
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meter_on_timer_en_q <= `RST_BIT;
      meter_off_timer_en_q <= `RST_BIT;
      meter_generator_on <= `RST_BIT;
    end else if (wr_meter_ctrl) begin
      meter_on_timer_en_q <= reg_wdata[`BIT_ON_TEN];
      meter_off_timer_en_q <= reg_wdata[`BIT_OFF_TEN];
      meter_generator_on <= reg_wdata[`BIT_GEN_ON];
    end
  end

  // tone cadence durations, one byte per address, no shadowing
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tone1_on_duration_q <= `RST_DUR;
      tone1_off_duration_q <= `RST_DUR;
      tone2_on_duration_q <= `RST_DUR;
      tone2_off_duration_q <= `RST_DUR;
    end else if (reg_wr) begin
      case (reg_addr)
        `ADDR_T1_ON_LO: begin
          tone1_on_duration_q[7:0] <= reg_wdata;
        end
        `ADDR_T1_ON_HI: begin
          tone1_on_duration_q[15:8] <= reg_wdata;
        end
        `ADDR_T1_OFF_LO: begin
          tone1_off_duration_q[7:0] <= reg_wdata;
        end
        `ADDR_T1_OFF_HI: begin
          tone1_off_duration_q[15:8] <= reg_wdata;
        end
        `ADDR_T2_ON_LO: begin
          tone2_on_duration_q[7:0] <= reg_wdata;
        end
        `ADDR_T2_ON_HI: begin
          tone2_on_duration_q[15:8] <= reg_wdata;
        end
        `ADDR_T2_OFF_LO: begin
          tone2_off_duration_q[7:0] <= reg_wdata;
        end
        `ADDR_T2_OFF_HI: begin
          tone2_off_duration_q[15:8] <= reg_wdata;
        end
        default: begin
          tone1_on_duration_q <= tone1_on_duration_q;
        end
      endcase
    end
  end

  // per-channel cadence inputs
  assign ch_gen_on = {tone2_generator_on, tone1_generator_on,
                      meter_generator_on, ring_generator_on};
  assign ch_on_en = {tone2_on_timer_en, tone1_on_timer_en,
                     meter_on_timer_en_q, ring_on_timer_en_q};
  assign ch_off_en = {tone2_off_timer_en, tone1_off_timer_en,
                      meter_off_timer_en_q, ring_off_timer_en_q};
  assign ch_on_dur = {tone2_on_duration_q, tone1_on_duration_q,
                      meter_on_duration, ring_on_duration};
  assign ch_off_dur = {tone2_off_duration_q, tone1_off_duration_q,
                       meter_off_duration, ring_off_duration};

  // one cadence sequencer per oscillator
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_CH; gi = gi + 1) begin : g_ch
      cadence_timer u_timer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .unit_tick(unit_tick_q),
        .gen_on(ch_gen_on[gi]),
        .on_timer_en(ch_on_en[gi]),
        .off_timer_en(ch_off_en[gi]),
        .on_duration(ch_on_dur[gi*16 +: 16]),
        .off_duration(ch_off_dur[gi*16 +: 16]),
        .output_active(ch_active[gi])
      );
    end
  endgenerate

  // registered activity status
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_output_active <= `RST_BIT;
      meter_output_active <= `RST_BIT;
      tone1_output_active <= `RST_BIT;
      tone2_output_active <= `RST_BIT;
    end else begin
      ring_output_active <= ch_active[`CH_RING];
      meter_output_active <= ch_active[`CH_METER];
      tone1_output_active <= ch_active[`CH_TONE1];
      tone2_output_active <= ch_active[`CH_TONE2];
    end
  end

  // line drive waits for a join point
  always @* begin
    line_state_d = line_state_q;
    case (line_state_q)
      LN_OFF: begin
        if (ring_output_active) begin
          line_state_d = ring_join_point ? LN_ON : LN_WAIT_ON;
        end
      end
      LN_WAIT_ON: begin
        if (!ring_output_active) begin
          line_state_d = LN_OFF;
        end else if (ring_join_point) begin
          line_state_d = LN_ON;
        end
      end
      LN_ON: begin
        if (!ring_output_active) begin
          line_state_d = ring_join_point ? LN_OFF : LN_WAIT_OFF;
        end
      end
      LN_WAIT_OFF: begin
        if (ring_output_active) begin
          line_state_d = LN_ON;
        end else if (ring_join_point) begin
          line_state_d = LN_OFF;
        end
      end
      default: begin
        line_state_d = LN_OFF;
      end
    endcase
    if (!ring_generator_on) begin
      line_state_d = LN_OFF;
    end
  end

  // line state and flag flops, flag never set while disabled
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_state_q <= LN_OFF;
      ring_on_line_flag <= `RST_BIT;
    end else begin
      line_state_q <= line_state_d;
      ring_on_line_flag <= (line_state_d == LN_ON) ||
                           (line_state_d == LN_WAIT_OFF);
    end
  end

  // read data selection
  always @* begin
    rd_mux = `RST_BYTE;
    case (reg_addr)
      `ADDR_RING_CTRL: begin
        rd_mux[`BIT_STATUS] = ring_output_active;
        rd_mux[`BIT_RSVD6] = 1'b0;
        rd_mux[`BIT_ON_LINE] = ring_on_line_flag;
        rd_mux[`BIT_ON_TEN] = ring_on_timer_en_q;
        rd_mux[`BIT_OFF_TEN] = ring_off_timer_en_q;
        rd_mux[`BIT_GEN_ON] = ring_generator_on;
        rd_mux[`BIT_DC_OFS] = ring_dc_offset_en;
        rd_mux[`BIT_SHAPE] = ring_shape_select;
      end
      `ADDR_METER_CTRL: begin
        rd_mux[`BIT_STATUS] = meter_output_active;
        rd_mux[`BIT_ON_TEN] = meter_on_timer_en_q;
        rd_mux[`BIT_OFF_TEN] = meter_off_timer_en_q;
        rd_mux[`BIT_GEN_ON] = meter_generator_on;
      end
      `ADDR_T1_ON_LO: begin
        rd_mux = tone1_on_duration_q[7:0];
      end
      `ADDR_T1_ON_HI: begin
        rd_mux = tone1_on_duration_q[15:8];
      end
      `ADDR_T1_OFF_LO: begin
        rd_mux = tone1_off_duration_q[7:0];
      end
      `ADDR_T1_OFF_HI: begin
        rd_mux = tone1_off_duration_q[15:8];
      end
      `ADDR_T2_ON_LO: begin
        rd_mux = tone2_on_duration_q[7:0];
      end
      `ADDR_T2_ON_HI: begin
        rd_mux = tone2_on_duration_q[15:8];
      end
      `ADDR_T2_OFF_LO: begin
        rd_mux = tone2_off_duration_q[7:0];
      end
      `ADDR_T2_OFF_HI: begin
        rd_mux = tone2_off_duration_q[15:8];
      end
      default: begin
        rd_mux = `RST_BYTE;
      end
    endcase
  end

  // read data register, loaded on a read strobe
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= `RST_BYTE;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end
  end

endmodule // ring_tone_cadence_control

/* File: bench/cadence_asserts.sv */
`timescale 1ns/10ps
// port-level checks of the cadence control block
module cadence_asserts #(
  parameter UNIT_CYCLES = 4 // cycles per unit
) (
  input wire ref_clk, // clock
  input wire rst_n, // reset, active low
  input wire [7:0] reg_addr, // address
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [7:0] reg_rdata, // read data
  input wire ring_generator_on, // ringing enable
  input wire ring_join_point, // join point
  input wire ring_output_active, // ringing on
  input wire ring_on_line_flag, // ringing on line
  input wire ring_dc_offset_en, // dc offset
  input wire ring_shape_select, // waveshape
  input wire meter_output_active, // metering on
  input wire meter_generator_on // metering enable
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_ring_idle_off: assert property (!ring_generator_on [*3] |->
    !ring_output_active) else $error("ringing on while disabled");
  a_meter_idle_off: assert property (!meter_generator_on [*3] |->
    !meter_output_active) else $error("metering on while disabled");
  a_line_takes_ring: assert property (ring_join_point &&
    ring_generator_on |=> ring_on_line_flag == $past(ring_output_active))
    else $error("line flag missed join point");
  a_line_flag_clear: assert property (!ring_generator_on |=>
    !ring_on_line_flag) else $error("line flag set while disabled");
  a_offset_write: assert property (reg_wr && reg_addr == 8'h22 |=>
    ring_dc_offset_en == $past(reg_wdata[1])) else $error("offset bit");
  a_shape_write: assert property (reg_wr && reg_addr == 8'h22 |=>
    ring_shape_select == $past(reg_wdata[0])) else $error("shape bit");
  a_ring_rsvd_zero: assert property (reg_rd && reg_addr == 8'h22 |=>
    !reg_rdata[6]) else $error("ringing reserved bit set");
  a_meter_rsvd_zero: assert property (reg_rd && reg_addr == 8'h23 |=>
    reg_rdata[6:5] == 2'b00 && reg_rdata[1:0] == 2'b00)
    else $error("metering reserved bits set");
endmodule // cadence_asserts

bind ring_tone_cadence_control cadence_asserts #(.UNIT_CYCLES(UNIT_CYCLES))
  chk (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ring_generator_on(ring_generator_on),
  .ring_join_point(ring_join_point), .ring_output_active(ring_output_active),
  .ring_on_line_flag(ring_on_line_flag), .ring_shape_select(ring_shape_select),
  .ring_dc_offset_en(ring_dc_offset_en),
  .meter_generator_on(meter_generator_on),
  .meter_output_active(meter_output_active));

/* File: bench/host_model.sv */
`timescale 1ns/10ps
// host side of the register port
module host_model (
  input wire ref_clk, // clock
  output reg [7:0] reg_addr, // address
  output reg [7:0] reg_wdata, // write data
  output reg reg_wr, // write strobe
  output reg reg_rd // read strobe
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // one-cycle write, data scrambled afterwards
  task wr(input [7:0] a, input [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask

  // one-cycle read plus a gap for the answer
  task rd(input [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
endmodule // host_model

/* File: bench/tb.sv */
`timescale 1ns/10ps
module tb;
  localparam UC = 4;
  reg ref_clk = 1'b0;
  reg rst_n = 1'b0;
  reg p1 = 1'b0;
  reg p2 = 1'b0;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, r_act, r_line, r_dc, r_shape;
  wire m_act, m_on, t1_act, t2_act;
  reg r_on = 1'b0, join_pt = 1'b0, t1_on = 1'b0, t2_on = 1'b0;
  reg t1_ae = 1'b0, t1_ie = 1'b0, t2_ae = 1'b0, t2_ie = 1'b0;
  reg [15:0] r_ad = 16'h0000, r_id = 16'h0000;
  reg [15:0] m_ad = 16'h0000, m_id = 16'h0000;
  reg [7:0] exp_q[$];
  reg [7:0] b;
  reg [7:0] tbl [0:7];
  integer n_fail = 0, n_tests = 0, i, n;
  wire [3:0] act = {t2_act, t1_act, m_act, r_act};

  always #4 ref_clk = ~ref_clk;

  host_model host (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));
  ring_tone_cadence_control #(.UNIT_CYCLES(UC)) uut (.ref_clk(ref_clk),
    .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ring_generator_on(r_on), .ring_join_point(join_pt),
    .ring_on_duration(r_ad), .ring_off_duration(r_id),
    .meter_on_duration(m_ad), .meter_off_duration(m_id),
    .tone1_generator_on(t1_on), .tone1_on_timer_en(t1_ae),
    .tone1_off_timer_en(t1_ie), .tone2_generator_on(t2_on),
    .tone2_on_timer_en(t2_ae), .tone2_off_timer_en(t2_ie),
    .ring_output_active(r_act), .ring_on_line_flag(r_line),
    .ring_dc_offset_en(r_dc), .ring_shape_select(r_shape),
    .meter_output_active(m_act), .meter_generator_on(m_on),
    .tone1_output_active(t1_act), .tone2_output_active(t2_act));

  task check(input [8*8-1:0] nm, input [15:0] seen, input [15:0] exp);
    n_tests = n_tests + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task test_done;
    repeat (3) @(negedge ref_clk);
    if (exp_q.size() != 0) n_fail = n_fail + 1;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // note the expected read data, then run the read
  task rd(input [7:0] a, input [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask

  // length of a run of one level on an output, capped at 400
  task runlen(input integer ch, input v, output integer k);
    k = 0;
    while (act[ch] === v && k < 400) begin
      @(negedge ref_clk);
      k = k + 1;
    end
  endtask

  // measure a whole on phase and the off phase after it
  task cad(input integer ch, input integer on_c, input integer off_c);
    runlen(ch, 1'b0, n);
    runlen(ch, 1'b1, n);
    runlen(ch, 1'b0, n);
    runlen(ch, 1'b1, n);
    check("on_len", n[15:0], 16'(on_c * UC));
    runlen(ch, 1'b0, n);
    check("off_len", n[15:0], 16'(off_c * UC));
  endtask

  // read answers compared on the falling edge one and a half cycles after the read edge
  always @(posedge ref_clk) begin
    p1 <= reg_rd;
    p2 <= p1;
    join_pt <= $urandom % 2;
  end
  always @(negedge ref_clk) begin
    if (p2 && exp_q.size() == 0) n_fail = n_fail + 1;
    else if (p2) check("rdata", reg_rdata, exp_q.pop_front());
  end

  // watchdog
  initial begin
    #(8 * 30000);
    n_fail = n_fail + 1;
    test_done;
  end

  initial begin
    void'($urandom(38497));
    tbl = '{8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values of all registers
    for (i = 8'h22; i <= 8'h2B; i = i + 1) rd(i[7:0], 8'h00);
    // duration bytes keep what was written
    for (i = 8'h24; i <= 8'h2B; i = i + 1) begin
      b = $urandom;
      host.wr(i[7:0], b);
      rd(i[7:0], b);
    end
    // writable and read-only control bits
    host.wr(8'h22, 8'hFF);
    rd(8'h22, 8'h1B);
    check("ring_ofs", {r_dc, r_shape}, 2'b11);
    host.wr(8'h23, 8'hFF);
    rd(8'h23, 8'h1C);
    check("meter_on", m_on, 1'b1);
    host.wr(8'h22, 8'h18);
    rd(8'h22, 8'h18);
    check("ring_shp", {r_dc, r_shape}, 2'b00);
    host.wr(8'h50, 8'hFF);
    rd(8'h50, 8'h00);
    // cadences of all four oscillators, tone 2 on-time zero
    for (i = 0; i < 8; i = i + 1) host.wr(8'h24 + i[7:0], tbl[i]);
    @(posedge ref_clk);
    r_ad <= 16'h0002;
    r_id <= 16'h0003;
    m_ad <= 16'h0003;
    m_id <= 16'h0001;
    {t1_ae, t1_ie, t2_ae, t2_ie} <= 4'hF;
    {r_on, t1_on, t2_on} <= 3'b111;
    cad(0, 2, 3);
    cad(1, 3, 1);
    cad(2, 1, 2);
    cad(3, 1, 3);
    // inactive timer off: tone 1 stays off once on phase ends
    @(posedge ref_clk);
    t1_ie <= 1'b0;
    runlen(2, 1'b0, n);
    runlen(2, 1'b1, n);
    runlen(2, 1'b0, n);
    check("t1_hold", n[15:0], 16'd400);
    // ringing disabled: output and line flag drop
    @(posedge ref_clk);
    r_on <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check("ring_off", {r_act, r_line}, 2'b00);
    // metering disabled through its control bit
    host.wr(8'h23, 8'h18);
    repeat (4) @(negedge ref_clk);
    check("meter_dn", {m_act, m_on}, 2'b00);
    test_done;
  end
endmodule // tb
